// File: core/pdm_top.sv
// Purpose: power-down mask and sleep control registers of a dual-channel converter
// Assumes: register strobes come from the serial configuration decoder on clk
// Notes:   read data appears one cycle after the read strobe
`timescale 1ns/10ps
`default_nettype none
`include "pdm_regs.svh"

// Notes on behaviour
// [R1] two masks exist; mask_enable (bit of 55h) decides if any mask applies
// [R2] bit 5 of control sleep_control chooses which mask is used
// [R3] first mask lives at 20h (cores) and 21h (buffers)
// [R4] second mask lives at 23h (cores) and 24h (buffers), same layout
// [R5] core register: upper nibble channel A, lower nibble channel B
// [R6] buffer fields: bits 7:6 channel B, 5:4 channel A; 00 on, 11 off
// [R7] a buffer field switches both buffers of its channel together
// [R8] host sets pin override before global sleep; global sleep then sleeps device
// [R9] while override is set the external sleep pin is ignored
// [R10] choice 0 uses first mask, choice 1 uses second mask
// [R11] reserved bits written zero by host; every field resets to zero
module pdm_top
    import pdm_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       cfg_wr,
    input  wire logic       cfg_rd,
    input  wire logic       cfg_master_page,
    input  wire logic [7:0] cfg_addr,
    input  wire logic [7:0] cfg_wdata,
    output var  logic [7:0] cfg_rdata,
    input  wire logic       mask_enable,
    input  wire logic       sleep_pin,
    output var  logic [3:0] core_off_chan_a,
    output var  logic [3:0] core_off_chan_b,
    output var  logic [1:0] buffer_off_chan_a,
    output var  logic [1:0] buffer_off_chan_b,
    output var  logic       device_asleep
);

    // =========================================================================
    // reset release and pin synchroniser
    logic       rst_meta_reg;
    logic       rst_sync_n;
    logic       pin_meta_reg;
    logic       pin_sync_reg;

    // reset asserts at once, releases through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_n   <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_n   <= rst_meta_reg;
        end
    end

    // external sleep pin is asynchronous to clk
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pin_meta_reg <= `PDM_RST_BIT;
            pin_sync_reg <= `PDM_RST_BIT;
        end else begin
            pin_meta_reg <= sleep_pin;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // =========================================================================
    // register storage
    pdm_byte_t  mask_one_core_off_reg;
    pdm_byte_t  mask_two_core_off_reg;
    pdm_buf_t   mask_one_buf_a_reg;
    pdm_buf_t   mask_one_buf_b_reg;
    pdm_buf_t   mask_two_buf_a_reg;
    pdm_buf_t   mask_two_buf_b_reg;
    logic       whole_device_sleep_reg;
    logic       ignore_sleep_pin_reg;
    logic       sleep_mask_choice_reg;
    logic       sleep_next;

    // one address comparison shared by every write strobe
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
        return addr == ofs;
    endfunction : reg_hit

    // write decode, qualified by the master page
    wire logic  wr_ok     = cfg_wr && cfg_master_page;
    wire logic  wr_c1     = wr_ok && reg_hit(cfg_addr, `PDM_OFS_MASK_ONE_CORE);  // see [R3]
    wire logic  wr_b1     = wr_ok && reg_hit(cfg_addr, `PDM_OFS_MASK_ONE_BUF);   // see [R3]
    wire logic  wr_c2     = wr_ok && reg_hit(cfg_addr, `PDM_OFS_MASK_TWO_CORE);  // see [R4]
    wire logic  wr_b2     = wr_ok && reg_hit(cfg_addr, `PDM_OFS_MASK_TWO_BUF);   // see [R4]
    wire logic  wr_ctl    = wr_ok && reg_hit(cfg_addr, `PDM_OFS_SLEEP_CTRL);

    // global sleep can only be set once the pin override is already set; otherwise a write clears it
    assign sleep_next = ignore_sleep_pin_reg ? cfg_wdata[`PDM_CTL_SLEEP_BIT]
                                             : `PDM_RST_BIT;                // see [R8]

    // core masks store the whole byte, all fields reset to zero
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mask_one_core_off_reg <= `PDM_RST_BYTE;                         // see [R11]
            mask_two_core_off_reg <= `PDM_RST_BYTE;
        end else begin
            if (wr_c1) mask_one_core_off_reg <= cfg_wdata;
            if (wr_c2) mask_two_core_off_reg <= cfg_wdata;
        end
    end

    // buffer masks keep only the two channel fields; reserved nibble not stored
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mask_one_buf_a_reg <= `PDM_RST_PAIR;
            mask_one_buf_b_reg <= `PDM_RST_PAIR;
            mask_two_buf_a_reg <= `PDM_RST_PAIR;
            mask_two_buf_b_reg <= `PDM_RST_PAIR;
        end else begin
            if (wr_b1) begin
                mask_one_buf_a_reg <= cfg_wdata[`PDM_BUF_A_HI:`PDM_BUF_A_LO]; // see [R6]
                mask_one_buf_b_reg <= cfg_wdata[`PDM_BUF_B_HI:`PDM_BUF_B_LO];
            end
            if (wr_b2) begin
                mask_two_buf_a_reg <= cfg_wdata[`PDM_BUF_A_HI:`PDM_BUF_A_LO];
                mask_two_buf_b_reg <= cfg_wdata[`PDM_BUF_B_HI:`PDM_BUF_B_LO];
            end
        end
    end

    // control register: global sleep, pin override, mask choice
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            whole_device_sleep_reg <= `PDM_RST_BIT;
            ignore_sleep_pin_reg   <= `PDM_RST_BIT;
            sleep_mask_choice_reg  <= `PDM_RST_BIT;
        end else if (wr_ctl) begin
            whole_device_sleep_reg <= sleep_next;
            ignore_sleep_pin_reg   <= cfg_wdata[`PDM_CTL_IGNORE_PIN_BIT];
            sleep_mask_choice_reg  <= cfg_wdata[`PDM_CTL_MASK_SEL_BIT];     // see [R2]
        end
    end

    // =========================================================================
    // read-back, reserved bits read as zero
    pdm_byte_t  rd_value;
    wire pdm_byte_t buf1_byte = {mask_one_buf_b_reg, mask_one_buf_a_reg, 4'h0};
    wire pdm_byte_t buf2_byte = {mask_two_buf_b_reg, mask_two_buf_a_reg, 4'h0};
    wire pdm_byte_t ctl_byte  = {whole_device_sleep_reg, ignore_sleep_pin_reg,
                                 sleep_mask_choice_reg, 5'h00};

    always_comb begin
        case (cfg_addr)
            `PDM_OFS_MASK_ONE_CORE: rd_value = mask_one_core_off_reg;
            `PDM_OFS_MASK_ONE_BUF:  rd_value = buf1_byte;
            `PDM_OFS_MASK_TWO_CORE: rd_value = mask_two_core_off_reg;
            `PDM_OFS_MASK_TWO_BUF:  rd_value = buf2_byte;
            `PDM_OFS_SLEEP_CTRL:    rd_value = ctl_byte;
            default:                rd_value = 8'h00;
        endcase
    end

    // read data registered one cycle after the strobe, held until the next read
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cfg_rdata <= `PDM_RST_BYTE;
        end else if (cfg_rd) begin
            cfg_rdata <= cfg_master_page ? rd_value : 8'h00;
        end
    end

    // =========================================================================
    // power-down request and mask selection
    // pin override picks the register bit over the synchronised pin
    wire logic      sleep_req = ignore_sleep_pin_reg ? whole_device_sleep_reg  // see [R9]
                                                     : pin_sync_reg;
    wire pdm_byte_t act_core  = sleep_mask_choice_reg ? mask_two_core_off_reg
                                                      : mask_one_core_off_reg; // see [R10]
    wire pdm_buf_t  act_buf_a = sleep_mask_choice_reg ? mask_two_buf_a_reg
                                                      : mask_one_buf_a_reg;
    wire pdm_buf_t  act_buf_b = sleep_mask_choice_reg ? mask_two_buf_b_reg
                                                      : mask_one_buf_b_reg;

    // a field counts as off when any bit is set, so forbidden codes never half-power
    function automatic logic buf_off(input pdm_buf_t code);
        return |code;
    endfunction : buf_off

    // code 11 switches both buffers; undefined codes treated as off if any bit set
    wire logic      buf_a_off = buf_off(act_buf_a);                         // see [R7]
    wire logic      buf_b_off = buf_off(act_buf_b);

    // without mask everything sleeps on request; with mask only masked blocks do
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            core_off_chan_a   <= `PDM_RST_NIBBLE;
            core_off_chan_b   <= `PDM_RST_NIBBLE;
            buffer_off_chan_a <= `PDM_RST_PAIR;
            buffer_off_chan_b <= `PDM_RST_PAIR;
            device_asleep     <= `PDM_RST_BIT;
        end else if (!sleep_req) begin
            core_off_chan_a   <= 4'h0;
            core_off_chan_b   <= 4'h0;
            buffer_off_chan_a <= 2'h0;
            buffer_off_chan_b <= 2'h0;
            device_asleep     <= 1'b0;
        // mask in force: only the selected blocks power down
        end else if (mask_enable) begin                                     // see [R1]
            core_off_chan_a   <= act_core[`PDM_CORE_A_HI:`PDM_CORE_A_LO];   // see [R5]
            core_off_chan_b   <= act_core[`PDM_CORE_B_HI:`PDM_CORE_B_LO];
            buffer_off_chan_a <= {2{buf_a_off}};
            buffer_off_chan_b <= {2{buf_b_off}};
            device_asleep     <= 1'b0;
        // no mask: the whole device sleeps
        end else begin
            core_off_chan_a   <= 4'hF;
            core_off_chan_b   <= 4'hF;
            buffer_off_chan_a <= 2'h3;
            buffer_off_chan_b <= 2'h3;
            device_asleep     <= 1'b1;
        end
    end

endmodule : pdm_top
`default_nettype wire

// File: pkg/pdm_pkg.sv
// Purpose: shared types of the power-down mask block
// Assumes: nothing beyond the register header
// Notes:   widths of the mask fields
`default_nettype none
// =============================================================================
// types
package pdm_pkg;
    typedef logic [7:0] pdm_byte_t;
    typedef logic [3:0] pdm_core_t;   // one nibble of core switches per channel
    typedef logic [1:0] pdm_buf_t;    // two-bit buffer field per channel
endpackage : pdm_pkg
`default_nettype wire

// File: pkg/pdm_regs.svh
// Purpose: offsets, field positions and reset values of the power-down mask registers
// Assumes: 8-bit registers on the master page of the configuration port
// Notes:   definitions only
`ifndef PDM_REGS_SVH
`define PDM_REGS_SVH

// =============================================================================
// register offsets
`define PDM_OFS_MASK_ONE_CORE   8'h20
`define PDM_OFS_MASK_ONE_BUF    8'h21
`define PDM_OFS_MASK_TWO_CORE   8'h23
`define PDM_OFS_MASK_TWO_BUF    8'h24
`define PDM_OFS_SLEEP_CTRL      8'h26

// =============================================================================
// field positions
`define PDM_CORE_A_HI           7
`define PDM_CORE_A_LO           4
`define PDM_CORE_B_HI           3
`define PDM_CORE_B_LO           0
`define PDM_BUF_B_HI            7
`define PDM_BUF_B_LO            6
`define PDM_BUF_A_HI            5
`define PDM_BUF_A_LO            4
`define PDM_CTL_SLEEP_BIT       7
`define PDM_CTL_IGNORE_PIN_BIT  6
`define PDM_CTL_MASK_SEL_BIT    5

// =============================================================================
// reset values
`define PDM_RST_BYTE            8'h00
`define PDM_RST_BIT             1'b0
`define PDM_RST_NIBBLE          4'h0
`define PDM_RST_PAIR            2'h0

`endif

// File: test/pdm_top_sva.sv
// Purpose: port checks of the power-down mask block
// Assumes: one clock domain, rst_n active low
// Notes:   bound to pdm_top at the foot
`timescale 1ns/10ps
`default_nettype none
// =============================================================================
// checker
module pdm_top_sva (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       cfg_rd,
    input wire logic       cfg_master_page,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_rdata,
    input wire logic       mask_enable,
    input wire logic [3:0] core_off_chan_a,
    input wire logic [3:0] core_off_chan_b,
    input wire logic [1:0] buffer_off_chan_a,
    input wire logic [1:0] buffer_off_chan_b,
    input wire logic       device_asleep
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // read port: refused reads, reserved bits and hold of read data
    a_rd_unmapped: assert property (
        cfg_rd && !(cfg_addr inside {8'h20, 8'h21, 8'h23, 8'h24, 8'h26}) |=> cfg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rd_nopage: assert property (
        cfg_rd && !cfg_master_page |=> cfg_rdata == 8'h00) else $error("page low read not zero");
    a_buf_resv: assert property (
        cfg_rd && cfg_master_page && (cfg_addr == 8'h21 || cfg_addr == 8'h24)
        |=> cfg_rdata[3:0] == 4'h0)
        else $error("buffer reserved bits read set");
    a_ctl_resv: assert property (
        cfg_rd && cfg_master_page && cfg_addr == 8'h26 |=> cfg_rdata[4:0] == 5'h00)
        else $error("control reserved bits read set");
    a_rd_hold: assert property (
        !cfg_rd |=> $stable(cfg_rdata)) else $error("read data moved without read");
    // power outputs
    a_buf_pair: assert property (
        buffer_off_chan_a[1] == buffer_off_chan_a[0]
        && buffer_off_chan_b[1] == buffer_off_chan_b[0])
        else $error("buffer pair split");
    a_asleep_full: assert property (
        device_asleep |-> {core_off_chan_a, core_off_chan_b, buffer_off_chan_a,
                           buffer_off_chan_b} == 12'hFFF)
        else $error("asleep but block powered");
    a_asleep_cause: assert property (
        device_asleep |-> !$past(mask_enable)) else $error("asleep while mask enabled");
    a_nomask_all: assert property (
        core_off_chan_a != 4'h0 && !$past(mask_enable) |-> device_asleep)
        else $error("partial power-down with mask off");
    a_reset_quiet: assert property (
        $rose(rst_n) |-> ##1 (core_off_chan_a == 4'h0 && !device_asleep))
        else $error("output set after reset");
endmodule : pdm_top_sva

bind pdm_top pdm_top_sva u_sva (.clk, .rst_n, .cfg_rd, .cfg_master_page, .cfg_addr, .cfg_rdata,
    .mask_enable, .core_off_chan_a, .core_off_chan_b, .buffer_off_chan_a, .buffer_off_chan_b,
    .device_asleep);
`default_nettype wire

// File: test/tb_top.sv
// Purpose: self-checking bench of the power-down mask block
// Assumes: registers reached through the strobe port
// Notes:   random masks with corner codes first
`timescale 1ns/10ps
`default_nettype none
// =============================================================================
// bench
module tb_top;
    import pdm_pkg::*;
    logic        clk, rst_n, cfg_wr, cfg_rd, cfg_master_page;
    logic        mask_enable, sleep_pin, device_asleep;
    logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata;
    logic [3:0]  core_off_chan_a, core_off_chan_b;
    logic [1:0]  buffer_off_chan_a, buffer_off_chan_b;
    logic [12:0] pw;
    logic [12:0] ep;
    int          bad_count = 0;
    int          compares = 0;
    pdm_byte_t   c1, b1, c2, b2, ctl;
    pdm_byte_t   adr[5] = '{8'h20, 8'h21, 8'h23, 8'h24, 8'h26};
    pdm_byte_t   corner[3] = '{8'h0F, 8'hF0, 8'hFF};
    // power outputs packed in the order exp_pwr builds them
    assign pw = {core_off_chan_a, core_off_chan_b, buffer_off_chan_a, buffer_off_chan_b,
                 device_asleep};
    pdm_top uut (.clk, .rst_n, .cfg_wr, .cfg_rd, .cfg_master_page, .cfg_addr, .cfg_wdata,
        .cfg_rdata,
        .mask_enable, .sleep_pin, .core_off_chan_a, .core_off_chan_b, .buffer_off_chan_a,
        .buffer_off_chan_b, .device_asleep);
    // expected power outputs
    function automatic logic [12:0] exp_pwr(pdm_byte_t c, pdm_byte_t b, logic req, logic me);
        if (!req)
            return 13'h0000;
        if (!me)
            return 13'h1FFF;
        return {c, {2{|b[5:4]}}, {2{|b[7:6]}}, 1'b0};
    endfunction : exp_pwr
    // compare read data
    task automatic chk_rd(pdm_byte_t exp, pdm_byte_t got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH cfg_rdata expected %h seen %h", exp, got);
        end
    endtask : chk_rd
    // compare the packed power outputs
    task automatic chk_pwr(logic [12:0] exp, logic [12:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH power_outputs expected %h seen %h", exp, got);
        end
    endtask : chk_pwr
    // one-cycle write strobe, taken at the edge after it is driven
    task automatic wr(pdm_byte_t a, pdm_byte_t d);
        @(posedge clk) {cfg_wr, cfg_addr, cfg_wdata} <= {1'b1, a, d};
        @(posedge clk) cfg_wr <= 1'b0;
    endtask : wr
    // one-cycle read strobe; data stands from the taking edge until the next read
    task automatic rd(pdm_byte_t a, pdm_byte_t e);
        @(posedge clk) {cfg_rd, cfg_addr} <= {1'b1, a};
        @(posedge clk) cfg_rd <= 1'b0;
        @(negedge clk) chk_rd(e, cfg_rdata);
    endtask : rd
    // let the outputs settle, then look half a cycle off the edge
    task automatic settle(int n, logic [12:0] e);
        repeat (n) @(posedge clk);
        @(negedge clk) chk_pwr(e, pw);
    endtask : settle
    task automatic complete_run;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run
    // clock and watchdog
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (6000) @(posedge clk);
        bad_count++;
        complete_run();
    end
    // main sequence
    initial begin
        {rst_n, cfg_wr, cfg_rd, mask_enable, sleep_pin, cfg_addr, cfg_wdata} = '0;
        cfg_master_page = 1'b1;
        void'($urandom(68));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (adr[i]) rd(adr[i], 8'h00);
        wr(8'h22, 8'hFF);
        rd(8'h22, 8'h00);
        @(posedge clk) cfg_master_page <= 1'b0;
        wr(8'h20, 8'hFF);
        rd(8'h20, 8'h00);
        @(posedge clk) cfg_master_page <= 1'b1;
        rd(8'h20, 8'h00);
        wr(8'h21, 8'hFF);
        rd(8'h21, 8'hF0);
        // override not yet stored, so the first sleep bit is dropped
        wr(8'h26, 8'hFF);
        rd(8'h26, 8'h60);
        wr(8'h26, 8'hFF);
        rd(8'h26, 8'hE0);
        // random masks; the first rounds apply the corner core codes through mask one
        for (int i = 0; i < 40; i++) begin
            c1 = (i < 3) ? corner[i] : 8'($urandom);
            c2 = 8'($urandom);
            b1 = {{2{1'($urandom)}}, {2{1'($urandom)}}, 4'h0};
            b2 = {{2{1'($urandom)}}, {2{1'($urandom)}}, 4'h0};
            ctl = (i < 3) ? 8'hC0 : {1'($urandom), 1'b1, 1'($urandom), 5'h00};
            @(posedge clk) mask_enable <= (i < 3) ? 1'b1 : 1'($urandom);
            wr(8'h20, c1);
            wr(8'h21, b1);
            wr(8'h23, c2);
            wr(8'h24, b2);
            wr(8'h26, ctl);
            ep = exp_pwr(ctl[5] ? c2 : c1, ctl[5] ? b2 : b1, ctl[7], mask_enable);
            settle(2, ep);
            rd(8'h26, ctl);
        end
        // pin path: override cleared, then set again with the pin still high
        wr(8'h26, 8'h00);
        @(posedge clk) {mask_enable, sleep_pin} <= 2'b01;
        settle(4, 13'h1FFF);
        wr(8'h26, 8'h40);
        settle(2, 13'h0000);
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
